/* logic/clock_gate_defines.svh */
/*
  Offsets, reset values, writable masks and field positions of the
  peripheral clock gate registers.
  Assumes byte addressing on a 32-bit register port.
*/
`ifndef CLOCK_GATE_DEFINES_SVH
`define CLOCK_GATE_DEFINES_SVH

`define REG_ADDR_W        8
`define REG_DATA_W        32
`define GATE_COUNT        22

`define HSB_GATE_OFS      8'h14
`define PB2_GATE_OFS      8'h18
`define HSB_GATE_RST      32'h0000_0014
`define PB2_GATE_RST      32'h0000_0000
`define HSB_GATE_MASK     32'h0000_1157
`define PB2_GATE_MASK     32'h0038_7E7D
`define READ_IDLE         32'h0000_0000

`define HSB_USB_BIT       12
`define HSB_EMC_BIT       8
`define HSB_CRC_BIT       6
`define HSB_FLASH_BIT     4
`define HSB_SRAM_BIT      2
`define HSB_DMA1_BIT      1
`define HSB_DMA0_BIT      0

`define PB2_TMR11_BIT     21
`define PB2_TMR10_BIT     20
`define PB2_TMR9_BIT      19
`define PB2_SER0_BIT      14
`define PB2_ADV2_BIT      13
`define PB2_SPI0_BIT      12
`define PB2_ADV1_BIT      11
`define PB2_CONV2_BIT     10
`define PB2_CONV1_BIT     9
`define PB2_PE_BIT        6
`define PB2_PD_BIT        5
`define PB2_PC_BIT        4
`define PB2_PB_BIT        3
`define PB2_PA_BIT        2
`define PB2_AFIO_BIT      0

`endif

/* logic/clock_gate_pkg.sv */
/*
  Types for the peripheral clock gate block: one bundle of gate
  enables or gated clocks, one bit per peripheral.
  Assumes clock_gate_defines.svh is on the include path.
*/
`include "clock_gate_defines.svh"

package clock_gate_pkg;

  typedef struct packed
  {
    logic usb_ctrl_clock_gate;
    logic ext_memory_ctrl_clock_gate;
    logic checksum_unit_clock_gate;
    logic flash_ctrl_sleep_clock_keep;
    logic onchip_ram_sleep_clock_keep;
    logic second_dma_clock_gate;
    logic first_dma_clock_gate;
    logic timer_eleven_clock_gate;
    logic timer_ten_clock_gate;
    logic timer_nine_clock_gate;
    logic first_serial_port_clock_gate;
    logic second_advanced_timer_clock_gate;
    logic first_spi_clock_gate;
    logic first_advanced_timer_clock_gate;
    logic second_converter_clock_gate;
    logic first_converter_clock_gate;
    logic io_port_e_clock_gate;
    logic io_port_d_clock_gate;
    logic io_port_c_clock_gate;
    logic io_port_b_clock_gate;
    logic io_port_a_clock_gate;
    logic alt_function_io_clock_gate;
  } gated_clocks_t;

  typedef logic [`REG_DATA_W-1:0] reg_word_t;
  typedef logic [`REG_ADDR_W-1:0] reg_addr_t;

endpackage

/* logic/glitch_free_gate.sv */
/*
  One glitch-free clock gate cell: a latch open while the clock is low
  holds the enable, and an AND passes the clock.
  Assumes enable is launched from flops on the same rising clock edge.
*/
`timescale 1ns/100ps

module glitch_free_gate
(
  input  wire logic clk_in,
  input  wire logic enable_in,
  output logic      gated_clk_out
);

  logic enable_latch;

  // Enable only changes while the clock is low, so no runt pulse
  always_latch
  begin
    if (!clk_in)
    begin
      enable_latch <= enable_in;
    end
  end

  assign gated_clk_out = clk_in & enable_latch;

endmodule

/* logic/peripheral_clock_gating_enables.sv */
/*
  Peripheral clock gate registers: the high-speed-bus enable register
  and the peripheral-bus-2 enable register, their gate enables and one
  glitch-free gate cell per peripheral clock.
  Assumes a register master on core_clk_in with one-cycle strobes, and
  a core sleep flag produced on the same clock.
*/
// Operation
// - High-speed bit 12 gates USB controller clock; software sets and clears.
// - High-speed bit 8 gates external memory controller clock.
// - High-speed bit 6 gates checksum unit clock.
// - High-speed bit 4 keeps flash controller clock running during sleep.
// - High-speed bit 2 keeps on-chip RAM interface clock during sleep.
// - High-speed bits 1 and 0 gate second and first DMA clocks.
// - Bus-2 register at offset 0x18 resets to zero, all clocks off.
// - Bus-2 bits 21, 20, 19 gate three extra timer clocks.
// - Bus-2 bit 12 gates first SPI clock.
// - Bus-2 bit 11 gates first advanced timer clock.
// - Bus-2 bits 10 and 9 gate second and first converter clocks.
// - Bus-2 bits 6 to 2 gate IO ports E, D, C, B, A.
// - Bus-2 bit 0 gates alternate-function IO clock.
// - Every enable bit reads back last written value until write or reset.
`timescale 1ns/100ps
`include "clock_gate_defines.svh"

module peripheral_clock_gating_enables
(
  input  wire logic                       core_clk_in,
  input  wire logic                       rst_n_in,
  input  wire logic                       core_sleep_in,
  input  wire clock_gate_pkg::reg_addr_t  reg_addr_in,
  input  wire clock_gate_pkg::reg_word_t  reg_wdata_in,
  input  wire logic                       reg_wr_in,
  input  wire logic                       reg_rd_in,
  output clock_gate_pkg::reg_word_t       reg_rdata_out,
  output clock_gate_pkg::gated_clocks_t   gate_state_out,
  output clock_gate_pkg::gated_clocks_t   clocks_out
);

  function automatic logic addr_hit
  (
    input clock_gate_pkg::reg_addr_t addr,
    input clock_gate_pkg::reg_addr_t ofs
  );
    addr_hit = (addr == ofs);
  endfunction

  clock_gate_pkg::reg_word_t     hsb_reg;
  clock_gate_pkg::reg_word_t     hsb_next;
  clock_gate_pkg::reg_word_t     pb2_reg;
  clock_gate_pkg::reg_word_t     pb2_next;
  clock_gate_pkg::reg_word_t     rdata_reg;
  clock_gate_pkg::reg_word_t     rdata_next;
  clock_gate_pkg::reg_word_t     read_sel;
  clock_gate_pkg::gated_clocks_t gate_en;
  clock_gate_pkg::gated_clocks_t gate_clk;
  logic [`GATE_COUNT-1:0]        gate_en_vec;
  logic [`GATE_COUNT-1:0]        gate_clk_vec;
  logic                          hsb_wr;
  logic                          pb2_wr;
  logic                          hsb_rd;
  logic                          pb2_rd;

  // Address decode
  assign hsb_wr = reg_wr_in & addr_hit(reg_addr_in, `HSB_GATE_OFS);
  assign pb2_wr = reg_wr_in & addr_hit(reg_addr_in, `PB2_GATE_OFS);
  assign hsb_rd = reg_rd_in & addr_hit(reg_addr_in, `HSB_GATE_OFS);
  assign pb2_rd = reg_rd_in & addr_hit(reg_addr_in, `PB2_GATE_OFS);

  // Reserved bits are masked off, so a careless write cannot set them
  assign hsb_next = hsb_wr
                  ? (reg_wdata_in & `HSB_GATE_MASK)
                  : hsb_reg;
  assign pb2_next = pb2_wr
                  ? (reg_wdata_in & `PB2_GATE_MASK)
                  : pb2_reg;

  // Unmapped reads answer zero
  assign read_sel = hsb_rd ? hsb_reg
                  : pb2_rd ? pb2_reg
                  : `READ_IDLE;
  assign rdata_next = read_sel;

  always_ff @(posedge core_clk_in)
  begin
    if (!rst_n_in)
    begin
      hsb_reg   <= `HSB_GATE_RST;
      pb2_reg   <= `PB2_GATE_RST;
      rdata_reg <= `READ_IDLE;
    end
    else
    begin
      hsb_reg   <= hsb_next;
      pb2_reg   <= pb2_next;
      rdata_reg <= rdata_next;
    end
  end

  assign reg_rdata_out = rdata_reg;

  // High-speed bus enables
  assign gate_en.usb_ctrl_clock_gate =
    hsb_reg[`HSB_USB_BIT];
  assign gate_en.ext_memory_ctrl_clock_gate =
    hsb_reg[`HSB_EMC_BIT];
  assign gate_en.checksum_unit_clock_gate =
    hsb_reg[`HSB_CRC_BIT];
  // Flash and RAM run while awake; the keep bits matter only asleep
  assign gate_en.flash_ctrl_sleep_clock_keep =
    hsb_reg[`HSB_FLASH_BIT] | ~core_sleep_in;
  assign gate_en.onchip_ram_sleep_clock_keep =
    hsb_reg[`HSB_SRAM_BIT] | ~core_sleep_in;
  assign gate_en.second_dma_clock_gate =
    hsb_reg[`HSB_DMA1_BIT];
  assign gate_en.first_dma_clock_gate =
    hsb_reg[`HSB_DMA0_BIT];

  // Peripheral bus 2 enables
  assign gate_en.timer_eleven_clock_gate =
    pb2_reg[`PB2_TMR11_BIT];
  assign gate_en.timer_ten_clock_gate =
    pb2_reg[`PB2_TMR10_BIT];
  assign gate_en.timer_nine_clock_gate =
    pb2_reg[`PB2_TMR9_BIT];
  assign gate_en.first_serial_port_clock_gate =
    pb2_reg[`PB2_SER0_BIT];
  assign gate_en.second_advanced_timer_clock_gate =
    pb2_reg[`PB2_ADV2_BIT];
  assign gate_en.first_spi_clock_gate =
    pb2_reg[`PB2_SPI0_BIT];
  assign gate_en.first_advanced_timer_clock_gate =
    pb2_reg[`PB2_ADV1_BIT];
  assign gate_en.second_converter_clock_gate =
    pb2_reg[`PB2_CONV2_BIT];
  assign gate_en.first_converter_clock_gate =
    pb2_reg[`PB2_CONV1_BIT];
  assign gate_en.io_port_e_clock_gate =
    pb2_reg[`PB2_PE_BIT];
  assign gate_en.io_port_d_clock_gate =
    pb2_reg[`PB2_PD_BIT];
  assign gate_en.io_port_c_clock_gate =
    pb2_reg[`PB2_PC_BIT];
  assign gate_en.io_port_b_clock_gate =
    pb2_reg[`PB2_PB_BIT];
  assign gate_en.io_port_a_clock_gate =
    pb2_reg[`PB2_PA_BIT];
  assign gate_en.alt_function_io_clock_gate =
    pb2_reg[`PB2_AFIO_BIT];

  assign gate_en_vec    = gate_en;
  assign gate_state_out = gate_en;

  // One latch gate per clock; sleep enters through the latch as well
  genvar gi;
  generate
    for (gi = 0; gi < `GATE_COUNT; gi = gi + 1)
    begin : g_gate
      glitch_free_gate u_gate
      (
        .clk_in        (core_clk_in),
        .enable_in     (gate_en_vec[gi]),
        .gated_clk_out (gate_clk_vec[gi])
      );
    end
  endgenerate

  assign gate_clk   = gate_clk_vec;
  assign clocks_out = gate_clk;

  // Checks
  default clocking chk_cb @(posedge core_clk_in);
  endclocking

  default disable iff (!rst_n_in);

  sequence hsb_write_s;
    reg_wr_in && addr_hit(reg_addr_in, `HSB_GATE_OFS);
  endsequence

  sequence pb2_write_s;
    reg_wr_in && addr_hit(reg_addr_in, `PB2_GATE_OFS);
  endsequence

  sequence hsb_read_s;
    reg_rd_in && addr_hit(reg_addr_in, `HSB_GATE_OFS);
  endsequence

  sequence pb2_read_s;
    reg_rd_in && addr_hit(reg_addr_in, `PB2_GATE_OFS);
  endsequence

  // Accesses that hit neither register must leave both alone
  sequence other_write_s;
    reg_wr_in && !addr_hit(reg_addr_in, `HSB_GATE_OFS) &&
    !addr_hit(reg_addr_in, `PB2_GATE_OFS);
  endsequence

  sequence other_read_s;
    reg_rd_in && !addr_hit(reg_addr_in, `HSB_GATE_OFS) &&
    !addr_hit(reg_addr_in, `PB2_GATE_OFS);
  endsequence

  usb_gate_a : assert property (
    hsb_write_s |=>
      gate_state_out.usb_ctrl_clock_gate ==
      $past(reg_wdata_in[`HSB_USB_BIT]))
    else $error("usb clock gate does not follow write");

  ext_mem_gate_a : assert property (
    hsb_write_s |=>
      gate_state_out.ext_memory_ctrl_clock_gate ==
      $past(reg_wdata_in[`HSB_EMC_BIT]))
    else $error("external memory gate does not follow write");

  checksum_gate_a : assert property (
    hsb_write_s |=>
      gate_state_out.checksum_unit_clock_gate ==
      $past(reg_wdata_in[`HSB_CRC_BIT]))
    else $error("checksum gate does not follow write");

  flash_sleep_a : assert property (
    core_sleep_in && !hsb_reg[`HSB_FLASH_BIT] |->
      !gate_state_out.flash_ctrl_sleep_clock_keep)
    else $error("flash clock runs in sleep without keep bit");

  ram_sleep_a : assert property (
    (hsb_write_s ##1 core_sleep_in) |->
      gate_state_out.onchip_ram_sleep_clock_keep ==
      $past(reg_wdata_in[`HSB_SRAM_BIT]))
    else $error("ram sleep keep does not follow write");

  dma_gates_a : assert property (
    hsb_write_s |=>
      {gate_state_out.second_dma_clock_gate,
       gate_state_out.first_dma_clock_gate} ==
      $past(reg_wdata_in[`HSB_DMA1_BIT:`HSB_DMA0_BIT]))
    else $error("dma gates do not follow write");

  pb2_reset_a : assert property (
    $rose(rst_n_in) |-> pb2_reg == `PB2_GATE_RST &&
      gate_state_out.io_port_a_clock_gate == 1'b0)
    else $error("bus-2 register not cleared by reset");

  extra_timers_a : assert property (
    pb2_write_s |=>
      {gate_state_out.timer_eleven_clock_gate,
       gate_state_out.timer_ten_clock_gate,
       gate_state_out.timer_nine_clock_gate} ==
      $past(reg_wdata_in[`PB2_TMR11_BIT:`PB2_TMR9_BIT]))
    else $error("extra timer gates do not follow write");

  spi_gate_a : assert property (
    pb2_write_s |=>
      gate_state_out.first_spi_clock_gate ==
      $past(reg_wdata_in[`PB2_SPI0_BIT]))
    else $error("spi gate does not follow write");

  adv_timer_a : assert property (
    pb2_write_s |=>
      gate_state_out.first_advanced_timer_clock_gate ==
      $past(reg_wdata_in[`PB2_ADV1_BIT]))
    else $error("advanced timer gate does not follow write");

  converter_gates_a : assert property (
    pb2_write_s |=>
      {gate_state_out.second_converter_clock_gate,
       gate_state_out.first_converter_clock_gate} ==
      $past(reg_wdata_in[`PB2_CONV2_BIT:`PB2_CONV1_BIT]))
    else $error("converter gates do not follow write");

  io_port_gates_a : assert property (
    pb2_write_s |=>
      {gate_state_out.io_port_e_clock_gate,
       gate_state_out.io_port_d_clock_gate,
       gate_state_out.io_port_c_clock_gate,
       gate_state_out.io_port_b_clock_gate,
       gate_state_out.io_port_a_clock_gate} ==
      $past(reg_wdata_in[`PB2_PE_BIT:`PB2_PA_BIT]))
    else $error("io port gates do not follow write");

  alt_func_gate_a : assert property (
    pb2_write_s |=>
      gate_state_out.alt_function_io_clock_gate ==
      $past(reg_wdata_in[`PB2_AFIO_BIT]))
    else $error("alternate function gate does not follow write");

  hold_value_a : assert property (
    !reg_wr_in |=> $stable(hsb_reg) && $stable(pb2_reg))
    else $error("enable register changed without a write");

  hsb_readback_a : assert property (
    hsb_write_s ##1 hsb_read_s |=>
      reg_rdata_out == ($past(reg_wdata_in, 2) & `HSB_GATE_MASK))
    else $error("high-speed register read back wrong");

  pb2_readback_a : assert property (
    pb2_write_s ##1 pb2_read_s |=>
      reg_rdata_out == ($past(reg_wdata_in, 2) & `PB2_GATE_MASK))
    else $error("bus-2 register read back wrong");

  reserved_zero_a : assert property (
    (hsb_reg & ~`HSB_GATE_MASK) == `READ_IDLE &&
    (pb2_reg & ~`PB2_GATE_MASK) == `READ_IDLE)
    else $error("reserved bit became set");

  read_idle_a : assert property (
    !reg_rd_in |=> reg_rdata_out == `READ_IDLE)
    else $error("read data present without a read");

  hsb_reset_a : assert property (
    $rose(rst_n_in) |-> hsb_reg == `HSB_GATE_RST)
    else $error("high-speed register not preset by reset");

  serial_gate_a : assert property (
    pb2_write_s |=>
      gate_state_out.first_serial_port_clock_gate ==
      $past(reg_wdata_in[`PB2_SER0_BIT]))
    else $error("serial port gate does not follow write");

  adv2_timer_a : assert property (
    pb2_write_s |=>
      gate_state_out.second_advanced_timer_clock_gate ==
      $past(reg_wdata_in[`PB2_ADV2_BIT]))
    else $error("second advanced timer gate does not follow write");

  awake_keep_a : assert property (
    !core_sleep_in |->
      gate_state_out.flash_ctrl_sleep_clock_keep &&
      gate_state_out.onchip_ram_sleep_clock_keep)
    else $error("flash or ram clock stopped while awake");

  ram_sleep_off_a : assert property (
    core_sleep_in && !hsb_reg[`HSB_SRAM_BIT] |->
      !gate_state_out.onchip_ram_sleep_clock_keep)
    else $error("ram clock runs in sleep without keep bit");

  unmapped_write_a : assert property (
    other_write_s |=> $stable(hsb_reg) && $stable(pb2_reg))
    else $error("write to another address changed a register");

  unmapped_read_a : assert property (
    other_read_s |=> reg_rdata_out == `READ_IDLE)
    else $error("read of another address returned data");

  pb2_cross_a : assert property (
    pb2_write_s |=> $stable(hsb_reg))
    else $error("bus-2 write disturbed the high-speed register");

  hsb_cross_a : assert property (
    hsb_write_s |=> $stable(pb2_reg))
    else $error("high-speed write disturbed the bus-2 register");

endmodule

/* sim/peripheral_clock_gating_enables_tb_top.sv */
/*
  Self-checking bench for the peripheral clock gate registers.
  Assumes the design package and defines header are compiled first.
*/
`timescale 1ns/100ps
`include "clock_gate_defines.svh"

module peripheral_clock_gating_enables_tb_top;
  logic                          core_clk_in = 1'b0;
  logic                          rst_n_in = 1'b0;
  logic                          core_sleep_in = 1'b0;
  clock_gate_pkg::reg_addr_t     reg_addr_in = 8'h00;
  clock_gate_pkg::reg_word_t     reg_wdata_in = 32'h0000_0000;
  logic                          reg_wr_in = 1'b0;
  logic                          reg_rd_in = 1'b0;
  clock_gate_pkg::reg_word_t     reg_rdata_out;
  clock_gate_pkg::gated_clocks_t gate_state_out;
  clock_gate_pkg::gated_clocks_t clocks_out;
  clock_gate_pkg::reg_word_t     hsb_m;
  clock_gate_pkg::reg_word_t     pb2_m;
  int                            errors = 0;
  int                            samples_checked = 0;
  int                            cycles = 0;
  int                            hsb_bits[7] = '{12, 8, 6, 4, 2, 1, 0};
  int                            pb2_bits[15] =
    '{21, 20, 19, 14, 13, 12, 11, 10, 9, 6, 5, 4, 3, 2, 0};

  always #4 core_clk_in = ~core_clk_in;

  peripheral_clock_gating_enables i_dut
  (
    .core_clk_in    (core_clk_in),
    .rst_n_in       (rst_n_in),
    .core_sleep_in  (core_sleep_in),
    .reg_addr_in    (reg_addr_in),
    .reg_wdata_in   (reg_wdata_in),
    .reg_wr_in      (reg_wr_in),
    .reg_rd_in      (reg_rd_in),
    .reg_rdata_out  (reg_rdata_out),
    .gate_state_out (gate_state_out),
    .clocks_out     (clocks_out)
  );

  // Expected enables; awake, flash and RAM clocks always run
  function automatic clock_gate_pkg::gated_clocks_t exp_gates(input logic s);
    exp_gates = {hsb_m[12], hsb_m[8], hsb_m[6], hsb_m[4] | ~s,
                 hsb_m[2] | ~s, hsb_m[1], hsb_m[0], pb2_m[21], pb2_m[20],
                 pb2_m[19], pb2_m[14], pb2_m[13], pb2_m[12], pb2_m[11],
                 pb2_m[10], pb2_m[9], pb2_m[6], pb2_m[5], pb2_m[4],
                 pb2_m[3], pb2_m[2], pb2_m[0]};
  endfunction

  function automatic clock_gate_pkg::reg_word_t model_rd(
    input clock_gate_pkg::reg_addr_t a);
    model_rd = (a == `HSB_GATE_OFS) ? hsb_m :
               (a == `PB2_GATE_OFS) ? pb2_m : `READ_IDLE;
  endfunction

  task automatic finish_test();
    $display("errors=%0d samples_checked=%0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic check_word(input clock_gate_pkg::reg_word_t got,
                            input clock_gate_pkg::reg_word_t exp);
    samples_checked++;
    if (got !== exp)
    begin
      errors++;
      $display("MISMATCH t=%0t word got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic check_gates(input clock_gate_pkg::gated_clocks_t got,
                             input clock_gate_pkg::gated_clocks_t exp);
    samples_checked++;
    if (got !== exp)
    begin
      errors++;
      $display("MISMATCH t=%0t gates got %h exp %h", $time, got, exp);
    end
  endtask

  // Starts right after a rising edge and leaves the strobe up
  task automatic reg_write(input clock_gate_pkg::reg_addr_t a,
                           input clock_gate_pkg::reg_word_t d);
    reg_wr_in <= 1'b1;
    reg_rd_in <= 1'b0;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    @(posedge core_clk_in);
    if (a == `HSB_GATE_OFS)
      hsb_m = d & `HSB_GATE_MASK;
    if (a == `PB2_GATE_OFS)
      pb2_m = d & `PB2_GATE_MASK;
  endtask

  // Read data stands in the one cycle after the strobe, zero after it
  task automatic rd_chk(input clock_gate_pkg::reg_addr_t a);
    reg_rd_in <= 1'b1;
    reg_wr_in <= 1'b0;
    reg_addr_in <= a;
    @(posedge core_clk_in);
    reg_rd_in <= 1'b0;
    #1 check_word(reg_rdata_out, model_rd(a));
    @(posedge core_clk_in);
    #1 check_word(reg_rdata_out, `READ_IDLE);
    @(posedge core_clk_in);
  endtask

  // Latch loads in the low phase, so the new gate shows a full high phase
  task automatic check_clocks();
    reg_wr_in <= 1'b0;
    reg_rd_in <= 1'b0;
    #1 check_gates(gate_state_out, exp_gates(core_sleep_in));
    @(posedge core_clk_in);
    #2 check_gates(clocks_out, exp_gates(core_sleep_in));
    @(negedge core_clk_in);
    #2 check_gates(clocks_out, '0);
    @(posedge core_clk_in);
  endtask

  task automatic wr_chk(input clock_gate_pkg::reg_addr_t a,
                        input clock_gate_pkg::reg_word_t d);
    reg_write(a, d);
    check_clocks();
  endtask

  always @(posedge core_clk_in)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      errors++;
      finish_test();
    end
  end

  initial
  begin
    hsb_m = `HSB_GATE_RST;
    pb2_m = `PB2_GATE_RST;
    repeat (6) @(posedge core_clk_in);
    rst_n_in <= 1'b1;
    check_clocks();
    rd_chk(`HSB_GATE_OFS);
    rd_chk(`PB2_GATE_OFS);
    // Every writable bit set, reserved bits kept at their reset value
    wr_chk(`HSB_GATE_OFS, `HSB_GATE_MASK);
    rd_chk(`HSB_GATE_OFS);
    core_sleep_in <= 1'b1;
    foreach (hsb_bits[i])
    begin
      wr_chk(`HSB_GATE_OFS, 32'h0000_0001 << hsb_bits[i]);
      rd_chk(`HSB_GATE_OFS);
    end
    wr_chk(`HSB_GATE_OFS, 32'h0000_0000);
    core_sleep_in <= 1'b0;
    check_clocks();
    foreach (pb2_bits[i])
    begin
      wr_chk(`PB2_GATE_OFS, 32'h0000_0001 << pb2_bits[i]);
      rd_chk(`PB2_GATE_OFS);
    end
    wr_chk(8'h1C, 32'h0000_0001);
    rd_chk(8'h1C);
    rd_chk(8'h10);
    reg_write(`PB2_GATE_OFS, `PB2_GATE_MASK);
    rd_chk(`PB2_GATE_OFS);
    reg_write(`PB2_GATE_OFS, 32'h0000_0000);
    reg_write(`HSB_GATE_OFS, 32'h0000_1000);
    rd_chk(`HSB_GATE_OFS);
    check_clocks();
    rd_chk(`PB2_GATE_OFS);
    finish_test();
  end
endmodule
